// ==== hdl/stmc_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
// Free-running up counter with a synchronous clear and hold.
module stmc_counter #(
    parameter int WIDTH = 10
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic clear,
    output logic [WIDTH-1:0] count
);
    logic [WIDTH-1:0] count_reg;

    // Clear takes priority so a start edge always begins from zero.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || clear) begin
            count_reg <= '0;
        end else if (run) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign count = count_reg;
endmodule
`default_nettype wire

// ==== hdl/stmc_edge_detect.sv ====
`timescale 1ns/10ps
`default_nettype none
// Registers a level and reports its rising and falling edges.
module stmc_edge_detect (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev_reg;

    // Previous sample of the level.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level;
        end
    end

    // Edges are combinational so the caller sees them in the same cycle.
    assign rise = level & ~prev_reg;
    assign fall = ~level & prev_reg;
endmodule
`default_nettype wire

// ==== hdl/stmc_pkg.sv ====
// What this block does
// - Mode field: 00 compare output, 01 capture, 10 PWM/single pulse, 11 timer.
// - Timer/counter mode leaves the output pin undriven; level and invert ignored.
// - Compare mode on A match: 00 hold, 01 low, 10 high, 11 toggle.
// - PWM mode pin function: 00 inactive, 01 active, 10 PWM, 11 single pulse.
// - Capture mode: 00 rising, 01 falling, 10 both edges, 11 disabled.
// - A match requesting the current initial level causes no visible change.
// - Run enable rising edge returns the output to its initial level.
// - Initial level sets pre-match level, or PWM active polarity.
// - Single pulse: initial level is driven at run enable rising edge.
// - Invert bit inverts the pin signal, except in timer/counter and capture modes.
// - Swap bit 0: P is period, A duty; 1 swaps the roles.
// - Clear source 1 clears on A match; 0 on P match or overflow.
// - Outside capture mode, overflow clearing applies only when the period compare bits are zero.
// - Clear source is ignored in PWM, single pulse and capture modes.
// - Counter is read-only over two bytes, low 7..0, high 9..8, reset zero.
// - High byte bits 7..2 of counter and compare A read as zero.
// - Compare A is a 10-bit read/write pair, reset zero.
// - Low byte write goes to a buffer; high byte write commits both.
// - High byte read latches the low byte; low read returns the buffer.
// - Period bits compare with counter bits 9..7; code 000 means 1024.
// - Run enable rising clears the counter; falling keeps its value.
package stmc_pkg;
    localparam int CNT_W = 10;
    localparam int ADDR_W = 4;
    // Word-aligned byte addresses of the register file.
    localparam logic [3:0] OFS_CTRL0 = 4'h0;
    localparam logic [3:0] OFS_MODE = 4'h4;
    localparam logic [3:0] OFS_CNTL = 4'h8;
    localparam logic [3:0] OFS_CNTH = 4'hc;
    // Compare A pair sits in the next aligned block.
    localparam logic [3:0] OFS_CMPL_IDX = 4'h0;
    localparam logic [7:0] OFS_CMPAL = 8'h10;
    localparam logic [7:0] OFS_CMPAH = 8'h14;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Control 0 field positions.
    localparam int C0_RUN = 3;
    localparam int C0_RP_LO = 0;
    // Mode control field positions.
    localparam int C1_M_LO = 6;
    localparam int C1_IO_LO = 4;
    localparam int C1_OC = 3;
    localparam int C1_POL = 2;
    localparam int C1_DPX = 1;
    localparam int C1_CCLR = 0;
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    localparam logic [1:0] IO_00 = 2'h0;
    localparam logic [1:0] IO_01 = 2'h1;
    localparam logic [1:0] IO_10 = 2'h2;
    localparam logic [1:0] IO_11 = 2'h3;
endpackage

// ==== hdl/stmc_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
// Standard timer mode control with Avalon-MM byte registers.
module stmc_timer #(
    parameter int CNT_WIDTH = stmc_pkg::CNT_W
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic capture_input_pin,
    output logic timer_output_pin,
    output logic timer_output_pin_oe_n,
    output logic capture_event,
    output logic compare_a_match,
    output logic compare_p_match
);
    logic [7:0] ctrl0_reg;
    logic [7:0] mode_control_reg;
    logic [CNT_WIDTH-1:0] compare_a_reg;
    logic [7:0] wr_buf_reg;
    logic [7:0] rd_buf_reg;
    logic [CNT_WIDTH-1:0] capture_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic pin_level_reg;
    logic pin_out_reg;
    logic pin_oe_n_reg;
    logic cap_prev_reg;
    logic cap_event_reg;
    logic match_a_reg;
    logic match_p_reg;
    logic pulse_active_reg;
    logic [CNT_WIDTH-1:0] count;
    logic runEnable;
    logic runRise;
    logic runFall;
    logic [1:0] modeSel;
    logic [1:0] pinFunc;
    logic initLevel;
    logic invertOut;
    logic [2:0] periodBits;
    logic matchA;
    logic matchP;
    logic overflow;
    logic counterClear;
    logic pwmActive;
    logic capRise;
    logic capFall;
    logic capHit;
    logic accWr;
    logic accRd;
    logic [7:0] wByte;

    assign runEnable = ctrl0_reg[stmc_pkg::C0_RUN];
    assign periodBits = ctrl0_reg[stmc_pkg::C0_RP_LO +: 3];
    assign modeSel = mode_control_reg[stmc_pkg::C1_M_LO +: 2];
    assign pinFunc = mode_control_reg[stmc_pkg::C1_IO_LO +: 2];
    assign initLevel = mode_control_reg[stmc_pkg::C1_OC];
    assign invertOut = mode_control_reg[stmc_pkg::C1_POL];
    assign wByte = avs_writedata[7:0];
    // Reads are looked up when the request is first seen, so their data stand in the
    // waitrequest-low cycle; writes land only at the edge that completes the transfer.
    assign accWr = avs_write & ~wait_reg;
    assign accRd = avs_read & wait_reg;

    // Period compare against the top three counter bits. The match fires on the last
    // count before the boundary, so a synchronous clear gives exactly 128 clocks per code.
    function automatic logic p_hit(input logic [2:0] rp, input logic [CNT_WIDTH-1:0] c);
        logic [CNT_WIDTH-1:0] nxt;
        nxt = c + 1'b1;
        p_hit = (rp != 3'h0) && (nxt[CNT_WIDTH-1 -: 3] == rp) && (nxt[6:0] == 7'h00);
    endfunction

    assign matchA = runEnable && (count == compare_a_reg) && (compare_a_reg != '0);
    assign matchP = runEnable && p_hit(periodBits, count);
    assign overflow = runEnable && (count == {CNT_WIDTH{1'b1}});

    // Clear source selection per mode.
    always_comb begin
        counterClear = runRise;
        if (modeSel == stmc_pkg::MODE_PWM) begin
            // Clear source bit ignored; swap bit picks the period register.
            if (mode_control_reg[stmc_pkg::C1_DPX]) begin
                counterClear = counterClear | matchA;
            end else begin
                counterClear = counterClear | matchP | (overflow && periodBits == 3'h0);
            end
        end else if (modeSel != stmc_pkg::MODE_CAP) begin
            if (mode_control_reg[stmc_pkg::C1_CCLR]) begin
                counterClear = counterClear | matchA;
            end else begin
                counterClear = counterClear | matchP;
                if (periodBits == 3'h0) begin
                    counterClear = counterClear | overflow;
                end
            end
        end else begin
            counterClear = counterClear | overflow;
        end
    end

    // PWM active window: duty from the non-period register.
    always_comb begin
        if (mode_control_reg[stmc_pkg::C1_DPX]) begin
            pwmActive = (count < {periodBits, 7'h00})
                || periodBits == 3'h0;
        end else begin
            pwmActive = count < compare_a_reg;
        end
    end

    stmc_edge_detect u_run_edge (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .level(runEnable),
        .rise(runRise),
        .fall(runFall)
    );

    stmc_counter #(.WIDTH(CNT_WIDTH)) u_counter (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(runEnable),
        .clear(counterClear),
        .count(count)
    );

    // Capture edge detection on the pin.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cap_prev_reg <= 1'b0;
        end else begin
            cap_prev_reg <= capture_input_pin;
        end
    end
    assign capRise = capture_input_pin & ~cap_prev_reg;
    assign capFall = ~capture_input_pin & cap_prev_reg;
    always_comb begin
        case (pinFunc)
            stmc_pkg::IO_00: capHit = capRise;
            stmc_pkg::IO_01: capHit = capFall;
            stmc_pkg::IO_10: capHit = capRise | capFall;
            default: capHit = 1'b0;
        endcase
    end

    // Captured counter value feeds the compare-A pair in capture mode.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            capture_reg <= '0;
            cap_event_reg <= 1'b0;
        end else begin
            cap_event_reg <= runEnable && modeSel == stmc_pkg::MODE_CAP && capHit;
            if (runEnable && modeSel == stmc_pkg::MODE_CAP && capHit) begin
                capture_reg <= count;
            end
        end
    end

    // Match event outputs, registered.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            match_a_reg <= 1'b0;
            match_p_reg <= 1'b0;
        end else begin
            match_a_reg <= matchA;
            match_p_reg <= matchP && !(modeSel != stmc_pkg::MODE_PWM
                && mode_control_reg[stmc_pkg::C1_CCLR]);
        end
    end

    // Compare-match pin level; reset to the initial level on start.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_level_reg <= 1'b0;
        end else if (runRise) begin
            pin_level_reg <= initLevel;
        end else if (modeSel == stmc_pkg::MODE_CMP && matchA) begin
            case (pinFunc)
                stmc_pkg::IO_01: pin_level_reg <= 1'b0;
                stmc_pkg::IO_10: pin_level_reg <= 1'b1;
                stmc_pkg::IO_11: pin_level_reg <= ~pin_level_reg;
                default: pin_level_reg <= pin_level_reg;
            endcase
        end else if (!runEnable && runFall == 1'b0 && modeSel != stmc_pkg::MODE_CMP) begin
            pin_level_reg <= initLevel;
        end
    end

    // Single pulse: leading edge at start, trailing at A match or stop.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pulse_active_reg <= 1'b0;
        end else if (runRise) begin
            pulse_active_reg <= 1'b1;
        end else if (matchA || !runEnable) begin
            pulse_active_reg <= 1'b0;
        end
    end

    // Pin driver; the pin is released in timer/counter and capture modes.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_out_reg <= 1'b0;
            pin_oe_n_reg <= 1'b1;
        end else begin
            pin_oe_n_reg <= 1'b0;
            case (modeSel)
                stmc_pkg::MODE_CMP: begin
                    pin_out_reg <= pin_level_reg ^ invertOut;
                end
                stmc_pkg::MODE_PWM: begin
                    case (pinFunc)
                        stmc_pkg::IO_00: pin_out_reg <= ~initLevel ^ invertOut;
                        stmc_pkg::IO_01: pin_out_reg <= initLevel ^ invertOut;
                        stmc_pkg::IO_10: begin
                            pin_out_reg <= (pwmActive ? initLevel : ~initLevel)
                                ^ invertOut;
                        end
                        default: begin
                            pin_out_reg <= ((pulse_active_reg || runRise) ? initLevel
                                : ~initLevel) ^ invertOut;
                        end
                    endcase
                end
                default: begin
                    pin_out_reg <= 1'b0;
                    pin_oe_n_reg <= 1'b1;
                end
            endcase
        end
    end

    // Register writes; one-cycle accepted access.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl0_reg <= stmc_pkg::RESET_BYTE;
            mode_control_reg <= stmc_pkg::RESET_BYTE;
            compare_a_reg <= '0;
            wr_buf_reg <= stmc_pkg::RESET_BYTE;
        end else if (accWr) begin
            if (avs_address == {4'h0, stmc_pkg::OFS_CTRL0}) begin
                ctrl0_reg <= wByte;
            end else if (avs_address == {4'h0, stmc_pkg::OFS_MODE}) begin
                mode_control_reg <= wByte;
            end else if (avs_address == stmc_pkg::OFS_CMPAL) begin
                wr_buf_reg <= wByte;
            end else if (avs_address == stmc_pkg::OFS_CMPAH) begin
                compare_a_reg <= {wByte[1:0], wr_buf_reg};
            end
        end
    end

    // Register reads and the high-then-low read buffer.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_reg <= '0;
            rd_buf_reg <= stmc_pkg::RESET_BYTE;
        end else if (accRd) begin
            rdata_reg <= {24'h000000, stmc_pkg::UNMAPPED_READ};
            if (avs_address == {4'h0, stmc_pkg::OFS_CTRL0}) begin
                rdata_reg[7:0] <= ctrl0_reg;
            end else if (avs_address == {4'h0, stmc_pkg::OFS_MODE}) begin
                rdata_reg[7:0] <= mode_control_reg;
            end else if (avs_address == {4'h0, stmc_pkg::OFS_CNTH}) begin
                rdata_reg[7:0] <= {6'h00, count[9:8]};
                rd_buf_reg <= count[7:0];
            end else if (avs_address == {4'h0, stmc_pkg::OFS_CNTL}) begin
                rdata_reg[7:0] <= rd_buf_reg;
            end else if (avs_address == stmc_pkg::OFS_CMPAH) begin
                rdata_reg[7:0] <= {6'h00, (modeSel == stmc_pkg::MODE_CAP ?
                    capture_reg[9:8] : compare_a_reg[9:8])};
                rd_buf_reg <= modeSel == stmc_pkg::MODE_CAP ?
                    capture_reg[7:0] : compare_a_reg[7:0];
            end else if (avs_address == stmc_pkg::OFS_CMPAL) begin
                rdata_reg[7:0] <= rd_buf_reg;
            end
        end
    end

    // Waitrequest drops for exactly one cycle after a request is seen.
    // It is kept as its own flop so the bus sees it straight from a register.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~((avs_read | avs_write) & wait_reg);
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign timer_output_pin = pin_out_reg;
    assign timer_output_pin_oe_n = pin_oe_n_reg;
    assign capture_event = cap_event_reg;
    assign compare_a_match = match_a_reg;
    assign compare_p_match = match_p_reg;

    property p_pin_released;
        @(posedge clk_sys) disable iff (sys_rst)
        (modeSel == stmc_pkg::MODE_TMR) |=> timer_output_pin_oe_n;
    endproperty
    a_pin_released: assert property (p_pin_released) else $error("Pin driven in timer mode.");

    property p_start_clears;
        @(posedge clk_sys) disable iff (sys_rst)
        runRise |=> (count == '0);
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("Start did not clear.");

    property p_stop_holds;
        @(posedge clk_sys) disable iff (sys_rst)
        (!runEnable && !runRise) |=> (count == $past(count));
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("Stopped counter moved.");

    property p_start_level;
        @(posedge clk_sys) disable iff (sys_rst)
        runRise |=> (pin_level_reg == $past(initLevel));
    endproperty
    a_start_level: assert property (p_start_level) else $error("Initial level lost.");

    property p_cclr_a;
        @(posedge clk_sys) disable iff (sys_rst)
        (matchA && modeSel == stmc_pkg::MODE_CMP && mode_control_reg[stmc_pkg::C1_CCLR])
            |=> (count == '0);
    endproperty
    a_cclr_a: assert property (p_cclr_a) else $error("A match did not clear.");

    property p_cmp_low;
        @(posedge clk_sys) disable iff (sys_rst)
        (matchA && !runRise && modeSel == stmc_pkg::MODE_CMP && pinFunc == stmc_pkg::IO_01)
            |=> !pin_level_reg;
    endproperty
    a_cmp_low: assert property (p_cmp_low) else $error("Match low failed.");

    sequence s_write_high;
        accWr && avs_address == stmc_pkg::OFS_CMPAH;
    endsequence
    property p_commit;
        @(posedge clk_sys) disable iff (sys_rst)
        s_write_high |=> (compare_a_reg[7:0] == $past(wr_buf_reg));
    endproperty
    a_commit: assert property (p_commit) else $error("Buffer not committed.");

    property p_high_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        (accRd && avs_address == {4'h0, stmc_pkg::OFS_CNTH}) |=> (avs_readdata[7:2] == 6'h00);
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("Unused bits set.");
endmodule
`default_nettype wire

// ==== tb/stmc_pin_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
// Far side of the pins: drives the capture input and resolves the output pad.
module stmc_pin_partner (
    input wire logic clk_sys,
    input wire logic timer_output_pin,
    input wire logic timer_output_pin_oe_n,
    output logic capture_input_pin,
    output wire logic padLevel
);
    // The pad has a pull-up, so a released pin reads high, never a stale level.
    assign padLevel = timer_output_pin_oe_n ? 1'b1 : timer_output_pin;
    // The input rests low between pulses.
    initial begin
        capture_input_pin = 1'b0;
    end
    // One high pulse, then an equal low gap; edges launch right after a clock edge.
    task automatic pulse(input int width);
        @(posedge clk_sys);
        capture_input_pin <= 1'b1;
        repeat (width) @(posedge clk_sys);
        capture_input_pin <= 1'b0;
        repeat (width) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ==== tb/stmc_timer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module stmc_timer_tb;
    logic clk_sys, sys_rst, avsRead, avsWrite, avsWaitRequest, capPin, outPin, outOeN;
    logic capEvent, cmpAMatch, cmpPMatch, padLevel;
    logic [7:0] avsAddress, rdata;
    logic [31:0] avsWriteData, avsReadData;
    logic [9:0] cnt, cnt2;
    int errCount = 0, samplesChecked = 0, nA, nP, nCap, nHigh, pFirst, pSecond;

    stmc_timer i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWriteData),
        .avs_readdata(avsReadData), .avs_waitrequest(avsWaitRequest),
        .capture_input_pin(capPin), .timer_output_pin(outPin),
        .timer_output_pin_oe_n(outOeN), .capture_event(capEvent),
        .compare_a_match(cmpAMatch), .compare_p_match(cmpPMatch));
    stmc_pin_partner i_partner (.clk_sys(clk_sys), .timer_output_pin(outPin),
        .timer_output_pin_oe_n(outOeN), .capture_input_pin(capPin), .padLevel(padLevel));

    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic wrapUp();
        $display("mismatches %0d, comparisons %0d", errCount, samplesChecked);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One bus access, held until waitrequest is seen low; the loop bound cuts a hang.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avsAddress <= a;
        avsWriteData <= {24'h000000, d};
        avsWrite <= w;
        avsRead <= ~w;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 40);
        rdata = avsReadData[7:0];
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        if (n >= 40) begin
            check(32'h00000000, 32'h00000001);
            wrapUp();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        xfer(a, 1'b0, 8'h00);
        check({24'h000000, rdata}, {24'h000000, exp});
    endtask

    // High byte first so the low byte comes from the latched copy.
    task automatic readCount(output logic [9:0] v);
        xfer(8'h0c, 1'b0, 8'h00);
        check({26'h0000000, rdata[7:2]}, 32'h00000000);
        v[9:8] = rdata[1:0];
        xfer(8'h08, 1'b0, 8'h00);
        v[7:0] = rdata;
    endtask

    // Configuration is only touched while stopped; flg is {level, invert, swap, clear}.
    task automatic setup(input logic [1:0] md, input logic [1:0] io, input logic [3:0] flg,
            input logic [2:0] per, input logic [9:0] cmpa);
        wr(8'h00, {5'h00, per});
        wr(8'h04, {md, io, flg});
        wr(8'h10, cmpa[7:0]);
        wr(8'h14, {6'h00, cmpa[9:8]});
        wr(8'h00, {4'h0, 1'b1, per});
    endtask

    // Counts pulses and pin high time over a window.
    task automatic watch(input int cycles);
        nA = 0;
        nP = 0;
        nCap = 0;
        nHigh = 0;
        pFirst = 0;
        pSecond = 0;
        for (int i = 0; i < cycles; i++) begin
            @(posedge clk_sys);
            nA += (cmpAMatch === 1'b1);
            nCap += (capEvent === 1'b1);
            nHigh += (outPin === 1'b1);
            if (cmpPMatch === 1'b1) begin
                nP++;
                if (nP == 1) pFirst = i;
                if (nP == 2) pSecond = i;
            end
        end
    endtask

    task automatic waitA();
        int n;
        n = 0;
        while (cmpAMatch !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        check(n < 200, 1);
        if (n >= 200) begin
            wrapUp();
        end
    endtask

    task automatic testRegs();
        check({outOeN, outPin}, 32'h00000002);
        rdChk(8'h0c, 8'h00);
        rdChk(8'h08, 8'h00);
        rdChk(8'h14, 8'h00);
        rdChk(8'h10, 8'h00);
        wr(8'h18, 8'hff);
        rdChk(8'h18, 8'h00);
        wr(8'h10, 8'ha5);
        rdChk(8'h14, 8'h00);
        rdChk(8'h10, 8'h00);
        wr(8'h14, 8'hff);
        rdChk(8'h14, 8'h03);
        rdChk(8'h10, 8'ha5);
        // Both control bytes read back what was written; the run bit stays clear.
        wr(8'h00, 8'h07);
        rdChk(8'h00, 8'h07);
        wr(8'h04, 8'h5a);
        rdChk(8'h04, 8'h5a);
    endtask

    task automatic testCounter();
        setup(2'h3, 2'h0, 4'hc, 3'h0, 10'h000);
        repeat (300) @(posedge clk_sys);
        check(outOeN, 1'b1);
        check(padLevel, 1'b1);
        wr(8'h00, 8'h00);
        readCount(cnt);
        check(cnt >= 300 && cnt <= 340, 1);
        repeat (20) @(posedge clk_sys);
        readCount(cnt2);
        check(cnt2, cnt);
        wr(8'h00, 8'h08);
        wr(8'h00, 8'h00);
        readCount(cnt);
        check(cnt > 0 && cnt < 12, 1);
    endtask

    // Every pin action, initial level and inversion in compare mode.
    task automatic testCompare();
        logic e;
        for (int k = 0; k < 16; k++) begin
            setup(2'h0, k[1:0], {k[2], k[3], 2'h0}, 3'h1, 10'h014);
            repeat (3) @(posedge clk_sys);
            check(outOeN, 1'b0);
            check(outPin, k[2] ^ k[3]);
            waitA();
            repeat (3) @(posedge clk_sys);
            e = (k[1:0] == 0) ? k[2] : (k[1:0] == 1) ? 1'b0 : (k[1:0] == 2) ? 1'b1 : ~k[2];
            check(outPin, e ^ k[3]);
            wr(8'h00, 8'h00);
        end
    endtask

    task automatic testClear();
        setup(2'h0, 2'h0, 4'h1, 3'h1, 10'h032);
        watch(400);
        check(nP == 0 && nA >= 7, 1);
        setup(2'h0, 2'h0, 4'h0, 3'h1, 10'h032);
        watch(400);
        check(pSecond - pFirst, 128);
        setup(2'h3, 2'h0, 4'h0, 3'h0, 10'h032);
        watch(1000);
        check(nA, 1);
    endtask

    task automatic pwm(input logic [1:0] io, input logic [3:0] flg, input logic [9:0] cmpa,
            input int win, input int exp);
        setup(2'h2, io, flg, 3'h1, cmpa);
        repeat (10) @(posedge clk_sys);
        watch(win);
        check(nHigh >= exp - 4 && nHigh <= exp + 4, 1);
    endtask

    task automatic testWave();
        pwm(2'h2, 4'h9, 10'h020, 256, 64);
        pwm(2'h2, 4'hd, 10'h020, 256, 192);
        pwm(2'h2, 4'h1, 10'h020, 256, 192);
        pwm(2'h2, 4'hb, 10'h100, 512, 256);
        pwm(2'h0, 4'h9, 10'h020, 256, 0);
        pwm(2'h1, 4'h9, 10'h020, 256, 256);
        setup(2'h2, 2'h3, 4'h8, 3'h0, 10'h028);
        repeat (3) @(posedge clk_sys);
        check(outPin, 1'b1);
        waitA();
        repeat (3) @(posedge clk_sys);
        check(outPin, 1'b0);
    endtask

    task automatic testCapture();
        for (int k = 0; k < 4; k++) begin
            setup(2'h1, k[1:0], 4'h0, 3'h0, 10'h000);
            fork
                watch(40);
                i_partner.pulse(8);
            join
            check(nCap, (k == 2) ? 2 : (k == 3) ? 0 : 1);
        end
    endtask

    // Reset for two cycles, then run each scenario in turn.
    initial begin
        sys_rst = 1'b1;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsAddress = 8'h00;
        avsWriteData = 32'h00000000;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        testRegs();
        testCounter();
        testCompare();
        testClear();
        testWave();
        testCapture();
        wrapUp();
    end
endmodule
`default_nettype wire
